// >>> hw/spm_line_sync.sv
// Two-flop synchroniser with edge-free output for one serial bus line.
// Assumes the line idles high, as on a two-wire bus.
`timescale 1ns/1ns
`include "spm_params.svh"

module spm_line_sync (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Line
    input wire logic line_in,
    output logic line_sync
);

    logic [`SPM_SYNC_STAGES-1:0] stage_reg;

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            stage_reg <= '1;
        else
            stage_reg <= {stage_reg[`SPM_SYNC_STAGES-2:0], line_in};
    end

    assign line_sync = stage_reg[`SPM_SYNC_STAGES-1];

endmodule : spm_line_sync

// >>> hw/spm_params.svh
// Constants for the sensor front end power-mode controller.
// Assumes inclusion by the design modules; hw/spm_pkg.sv does not include it.
`ifndef SPM_PARAMS_SVH
`define SPM_PARAMS_SVH

`define SPM_ADDR_WAKE 8'h04
`define SPM_ADDR_SLEEP 8'h05
`define SPM_ADDR_REG_SET 8'h07
`define SPM_ADDR_CUR_SENSE 8'h08
`define SPM_ADDR_SEL0 8'h10
`define SPM_ADDR_SEL1 8'h12
`define SPM_ADDR_SEL2 8'h14
`define SPM_ADDR_SEL3 8'h15
`define SPM_ADDR_SEL4 8'h18
`define SPM_ADDR_SEL5 8'h1a
`define SPM_ADDR_SEL6 8'h1c
`define SPM_ADDR_SEL7 8'h1e
`define SPM_VSEL_BIT 0
`define SPM_SDN_BIT 1
`define SPM_REG_SET_RESET 8'h00
`define SPM_SLAVE_ADDR 7'h48
`define SPM_SYNC_STAGES 2

`endif

// >>> hw/spm_pkg.sv
// Types for the sensor front end power-mode controller.
// Assumes nothing beyond a SystemVerilog compiler.
package spm_pkg;

    typedef enum logic [2:0] {
        SPM_IDLE = 3'b000,
        SPM_DEV_ADDR = 3'b001,
        SPM_REG_ADDR = 3'b011,
        SPM_PARAM = 3'b010,
        SPM_READ = 3'b110,
        SPM_IGNORE = 3'b111
    } spm_bus_state_e;

endpackage : spm_pkg

// >>> hw/spm_power_ctrl.sv
// Two-wire slave command interpreter for regulator, sense and sleep.
// Assumes bus lines are slow against mclk and pulled up outside.
`timescale 1ns/1ns
`include "spm_params.svh"

module spm_power_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Analog controls
    output logic regulator_enable,
    output logic voltage_select,
    output logic analog_enable,
    output logic current_sense_mode,
    output logic input_select_valid,
    output logic [7:0] input_select_addr,
    output logic sleep_mode
);

    logic scl_s;
    logic sda_s;
    logic scl_d_reg;
    logic sda_d_reg;

    spm_line_sync u_scl_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .line_in(scl_in),
        .line_sync(scl_s)
    );

    spm_line_sync u_sda_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .line_in(sda_in),
        .line_sync(sda_s)
    );

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end
        else
        begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    wire scl_rise = scl_s & ~scl_d_reg;
    wire scl_fall = ~scl_s & scl_d_reg;
    wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    wire stop_cond = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    spm_pkg::spm_bus_state_e state_reg;
    spm_pkg::spm_bus_state_e state_next;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic ack_phase_reg;
    logic ack_ok_reg;
    logic [7:0] addr_reg;
    logic [7:0] reg_set_reg;
    logic sleep_reg;
    logic sense_reg;
    logic sda_out_reg;
    logic sda_oe_reg;
    logic sel_valid_reg;
    logic [7:0] sel_addr_reg;

    // Byte completes on the eighth rising clock edge
    wire byte_done = scl_rise & ~ack_phase_reg & (bit_cnt_reg == 4'h7);
    wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
    // Ack slot runs from the eighth fall to the ninth; the ninth rise
    // must not be counted as a data bit of the next byte
    wire ack_first_fall = scl_fall & ack_phase_reg & (bit_cnt_reg == 4'h0);
    wire ack_end = scl_fall & ack_phase_reg & (bit_cnt_reg == 4'h1);

    wire addr_match = rx_byte[7:1] == `SPM_SLAVE_ADDR;
    wire rd_req = rx_byte[0];

    wire is_wake = rx_byte == `SPM_ADDR_WAKE;
    wire is_sleep = rx_byte == `SPM_ADDR_SLEEP;
    wire is_reg_set = rx_byte == `SPM_ADDR_REG_SET;
    wire is_sense = rx_byte == `SPM_ADDR_CUR_SENSE;
    // One comparator per input-select address
    wire [7:0] sel_hit;
    wire [63:0] sel_table;
    assign sel_table = {`SPM_ADDR_SEL7, `SPM_ADDR_SEL6, `SPM_ADDR_SEL5,
        `SPM_ADDR_SEL4, `SPM_ADDR_SEL3, `SPM_ADDR_SEL2, `SPM_ADDR_SEL1,
        `SPM_ADDR_SEL0};
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_sel
            assign sel_hit[gi] = rx_byte == sel_table[gi*8 +: 8];
        end
    endgenerate
    wire is_sel = |sel_hit;
    // Asleep, only wake and regulator settings are decoded
    wire cmd_allowed = ~sleep_reg | is_wake | is_reg_set;

    wire in_reg_addr = state_reg == spm_pkg::SPM_REG_ADDR;
    wire in_param = state_reg == spm_pkg::SPM_PARAM;
    wire in_read = state_reg == spm_pkg::SPM_READ;
    wire addr_byte = byte_done & in_reg_addr;
    wire param_byte = byte_done & in_param & (addr_reg == `SPM_ADDR_REG_SET);

    // Acknowledge decision for the byte just received
    wire ack_dev = (state_reg == spm_pkg::SPM_DEV_ADDR) & addr_match;
    wire ack_this = ack_dev | in_reg_addr | in_param;

    always_comb
    begin
        state_next = state_reg;
        if (start_cond)
            state_next = spm_pkg::SPM_DEV_ADDR;
        else if (stop_cond)
            state_next = spm_pkg::SPM_IDLE;
        else if (byte_done)
        begin
            case (state_reg)
                spm_pkg::SPM_DEV_ADDR:
                    if (!addr_match)
                        state_next = spm_pkg::SPM_IGNORE;
                    else if (rd_req)
                        state_next = spm_pkg::SPM_READ;
                    else
                        state_next = spm_pkg::SPM_REG_ADDR;
                spm_pkg::SPM_REG_ADDR:
                    state_next = spm_pkg::SPM_PARAM;
                spm_pkg::SPM_PARAM:
                    state_next = spm_pkg::SPM_PARAM;
                // Single-byte register: line released after one byte
                spm_pkg::SPM_READ:
                    state_next = spm_pkg::SPM_IGNORE;
                spm_pkg::SPM_IGNORE:
                    state_next = spm_pkg::SPM_IGNORE;
                default:
                    state_next = spm_pkg::SPM_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            state_reg <= spm_pkg::SPM_IDLE;
        else
            state_reg <= state_next;
    end

    // Bit counter, shifter and acknowledge phase
    always_ff @(posedge mclk)
    begin
        if (!rst_b || start_cond || stop_cond)
        begin
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
            shift_reg <= 8'h00;
        end
        else if (byte_done)
        begin
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b1;
            ack_ok_reg <= ack_this;
            shift_reg <= rx_byte;
        end
        else if (ack_first_fall)
            bit_cnt_reg <= 4'h1;
        else if (ack_end)
        begin
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            ack_ok_reg <= 1'b0;
        end
        else if (scl_rise && !ack_phase_reg)
        begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= rx_byte;
        end
    end

    // Read data: the held regulator byte, answered asleep or awake
    // MSB goes out at the end of the ack slot, then one bit per fall
    logic [3:0] rd_bit_idx;
    assign rd_bit_idx = ack_phase_reg ? 4'h7 : 4'h7 - bit_cnt_reg;
    wire rd_bit = reg_set_reg[rd_bit_idx[2:0]];
    wire rd_drive_low = in_read & ~rd_bit;

    // Line driven only on falling clock, so data is stable while high
    always_ff @(posedge mclk)
    begin
        if (!rst_b || start_cond || stop_cond)
        begin
            sda_out_reg <= 1'b1;
            sda_oe_reg <= 1'b0;
        end
        else if (scl_fall)
        begin
            sda_out_reg <= 1'b0;
            // Pull low in the ack slot only for bytes this slave accepts
            if (ack_first_fall)
                sda_oe_reg <= ack_ok_reg;
            else
                sda_oe_reg <= rd_drive_low;
        end
    end

    // Command execution on the register address byte
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            addr_reg <= 8'h00;
            sleep_reg <= 1'b0;
            sense_reg <= 1'b0;
            sel_valid_reg <= 1'b0;
            sel_addr_reg <= 8'h00;
        end
        else
        begin
            sel_valid_reg <= 1'b0;
            if (addr_byte)
            begin
                addr_reg <= cmd_allowed ? rx_byte : 8'hff;
                if (cmd_allowed && is_sleep)
                    sleep_reg <= 1'b1;
                if (is_wake)
                    sleep_reg <= 1'b0;
                if (cmd_allowed && is_sense)
                    sense_reg <= 1'b1;
                if (cmd_allowed && is_sel)
                begin
                    sense_reg <= 1'b0;
                    sel_valid_reg <= 1'b1;
                    sel_addr_reg <= rx_byte;
                end
            end
        end
    end

    // Settings never touched by sleep transitions
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            reg_set_reg <= `SPM_REG_SET_RESET;
        else if (param_byte)
            reg_set_reg <= {6'h00, rx_byte[1:0]};
    end

    // Output flops
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            regulator_enable <= 1'b1;
            voltage_select <= 1'b0;
            analog_enable <= 1'b1;
            current_sense_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else
        begin
            regulator_enable <= ~sleep_reg
                | ~reg_set_reg[`SPM_SDN_BIT];
            voltage_select <= reg_set_reg[`SPM_VSEL_BIT];
            analog_enable <= ~sleep_reg;
            current_sense_mode <= sense_reg & ~sleep_reg;
            sleep_mode <= sleep_reg;
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign input_select_valid = sel_valid_reg;
    assign input_select_addr = sel_addr_reg;

endmodule : spm_power_ctrl

// >>> verif/spm_host_model.sv
// Two-wire bus master model standing in for the host controller.
// Assumes a pulled-up data wire resolved by the testbench.
`timescale 1ns/1ns
module spm_host_model (
    // Clock
    input wire logic mclk,
    // Bus
    input wire logic sda,
    output logic scl,
    output logic sda_m
);
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // Five mclk per phase keeps well above the four the slave needs
    task hold;
        repeat (5) @(negedge mclk);
    endtask : hold
    task pulse(output logic s);
        scl = 1'b1;
        hold();
        s = sda;
        scl = 1'b0;
        hold();
    endtask : pulse
    task wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            sda_m = b[i];
            hold();
            pulse(s);
        end
        sda_m = 1'b1;
        hold();
        pulse(s);
        ack = !s;
    endtask : wr_byte
    task start;
        sda_m = 1'b1;
        scl = 1'b1;
        hold();
        sda_m = 1'b0;
        hold();
        scl = 1'b0;
        hold();
    endtask : start
    task stop;
        sda_m = 1'b0;
        hold();
        scl = 1'b1;
        hold();
        sda_m = 1'b1;
        hold();
    endtask : stop
    task cmd(input logic [7:0] ra, input logic [7:0] p, input bit np,
        output logic [2:0] acks);
        start();
        wr_byte(8'h90, acks[2]);
        wr_byte(ra, acks[1]);
        acks[0] = 1'b1;
        if (np)
            wr_byte(p, acks[0]);
        stop();
    endtask : cmd
    task rd(output logic [7:0] b, output logic a);
        logic s;
        start();
        wr_byte(8'h91, a);
        for (int i = 0; i < 8; i++)
        begin
            pulse(s);
            b = {b[6:0], s};
        end
        pulse(s);
        stop();
    endtask : rd
endmodule : spm_host_model

// >>> verif/spm_power_ctrl_properties.sv
// Checker of the power-mode outputs of the two-wire command block.
// Assumes a bind onto spm_power_ctrl; sees only its ports.
`timescale 1ns/1ns
module spm_power_ctrl_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Analog controls
    input wire logic regulator_enable,
    input wire logic voltage_select,
    input wire logic analog_enable,
    input wire logic current_sense_mode,
    input wire logic input_select_valid,
    input wire logic [7:0] input_select_addr,
    input wire logic sleep_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_awake_reg_on: assert property (!sleep_mode |-> regulator_enable)
        else $error("regulator off while active");
    a_analog_follow: assert property (analog_enable == !sleep_mode)
        else $error("analog enable disagrees with sleep");
    a_sleep_sense_off: assert property (sleep_mode |-> !current_sense_mode)
        else $error("sense mode shown while asleep");
    a_sleep_no_select: assert property
        (sleep_mode && $past(sleep_mode) |-> !input_select_valid)
        else $error("input select taken while asleep");
    a_select_ends_sense: assert property
        (input_select_valid |=> !current_sense_mode)
        else $error("sense mode kept after select");
    a_select_one_pulse: assert property
        (input_select_valid |=> !input_select_valid)
        else $error("select pulse too long");
    a_select_addr_ok: assert property (input_select_valid |->
        input_select_addr inside {8'h10, 8'h12, 8'h14, 8'h15, 8'h18,
        8'h1a, 8'h1c, 8'h1e})
        else $error("select address not an input select");
    a_ack_held: assert property ($rose(sda_oe) |=> sda_oe [*3])
        else $error("acknowledge dropped early");
endmodule : spm_power_ctrl_chk
bind spm_power_ctrl spm_power_ctrl_chk u_chk (.mclk(mclk), .rst_b(rst_b),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .regulator_enable(regulator_enable), .voltage_select(voltage_select),
    .analog_enable(analog_enable), .current_sense_mode(current_sense_mode),
    .input_select_valid(input_select_valid),
    .input_select_addr(input_select_addr), .sleep_mode(sleep_mode));

// >>> verif/spm_power_ctrl_test.sv
// Self-checking bench of the power-mode command block.
// Assumes the host model drives the bus at the falling mclk edge.
`timescale 1ns/1ns
module spm_power_ctrl_test;
    logic mclk, rst_b, scl, sda_m, sda, sda_out, sda_oe;
    logic reg_en, vsel, an_en, sense, sel_v, sleep;
    logic [7:0] sel_a;
    int error_cnt = 0;
    int total_checks = 0;
    logic [7:0] sel_cnt = 8'h00;
    always @(posedge mclk)
        if (sel_v === 1'b1)
            sel_cnt <= sel_cnt + 8'h01;
    // Status byte: sleep, sense, analog, voltage, regulator
    wire [7:0] st = {3'h0, sleep, sense, an_en, vsel, reg_en};
    assign sda = sda_m & ~(sda_oe & ~sda_out);
    spm_power_ctrl u_spm_power_ctrl (.mclk(mclk), .rst_b(rst_b),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .regulator_enable(reg_en), .voltage_select(vsel),
        .analog_enable(an_en), .current_sense_mode(sense),
        .input_select_valid(sel_v), .input_select_addr(sel_a),
        .sleep_mode(sleep));
    spm_host_model u_spm_host_model (.mclk(mclk), .sda(sda), .scl(scl),
        .sda_m(sda_m));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task send(input logic [7:0] ra, input logic [7:0] p, input bit np);
        logic [2:0] acks;
        u_spm_host_model.cmd(ra, p, np, acks);
        chk("acks", {5'h0, acks}, 8'h07);
    endtask : send
    task rd_chk(input logic [7:0] exp);
        logic [7:0] b;
        logic a;
        u_spm_host_model.rd(b, a);
        chk("read ack", {7'h0, a}, 8'h01);
        chk("readback", b, exp);
    endtask : rd_chk
    task t_reset;
        chk("status", st, 8'h05);
        rd_chk(8'h00);
    endtask : t_reset
    task t_reg_set;
        send(8'h07, 8'h01, 1);
        chk("status", st, 8'h07);
        send(8'h07, 8'hfe, 1);
        chk("status", st, 8'h05);
        rd_chk(8'h02);
        send(8'h07, 8'h03, 1);
        chk("status", st, 8'h07);
    endtask : t_reg_set
    task t_sense;
        logic [7:0] sel[8] = '{8'h10, 8'h12, 8'h14, 8'h15, 8'h18, 8'h1a,
            8'h1c, 8'h1e};
        foreach (sel[i])
        begin
            send(8'h08, 8'h00, 0);
            chk("status", st, 8'h0f);
            send(sel[i], 8'h00, 0);
            chk("status", st, 8'h07);
            chk("select", sel_a, sel[i]);
        end
        chk("select pulses", sel_cnt, 8'h08);
    endtask : t_sense
    task t_sleep;
        send(8'h08, 8'h00, 0);
        send(8'h05, 8'h00, 0);
        chk("status", st, 8'h12);
        send(8'h10, 8'h00, 0);
        chk("select", sel_a, 8'h1e);
        chk("select pulses", sel_cnt, 8'h08);
        send(8'h07, 8'h01, 1);
        chk("status", st, 8'h13);
        rd_chk(8'h01);
        send(8'h04, 8'h00, 0);
        chk("status", st, 8'h0f);
    endtask : t_sleep
    task give_verdict;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        rst_b = 1'b0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        t_reset();
        t_reg_set();
        t_sense();
        t_sleep();
        give_verdict();
    end
    // About 8500 cycles expected; seven times that means a hang
    initial
    begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        give_verdict();
    end
endmodule : spm_power_ctrl_test
